//--- hdl/sas_top.sv
// converter sequencer top: ahb-lite registers, sequencing, results
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/1ps
`include "sas_defines.svh"

// What this block does
// RL1 - acquisition field zero: start ends sampling and converts directly
// RL2 - nonzero field: keep sampling chosen periods, then convert on own
// RL3 - field decodes 20,16,12,8,6,4,2 periods; zero means none
// RL4 - at end clear running bit, set done flag, resume sampling
// RL5 - no status tells acquisition apart from conversion
// RL6 - one 12-bit conversion lasts 11 conversion clock periods
// RL7 - clock select gives 2..64 oscillator periods; x11 picks rc
// RL8 - convert selected channel whatever its pin direction
// RL9 - port reads give zero for pins set as analog inputs
// RL10 - clearing running bit aborts; result pair left untouched
// RL11 - after end or abort wait two periods, then sample again
// RL12 - zero acquisition field: delay start by one instruction
// RL13 - software enables the converter before setting running bit
// RL14 - enabled special trigger sets running bit like software start
// RL15 - special triggers ignored while the converter is off
// RL16 - trigger select 0 picks compare unit, 1 picks charge unit
// RL17 - calibrate bit: next start does dummy offset conversion
// RL18 - software recalibrates after reset and condition changes
// RL19 - result justify 1 right, 0 left in result pair
// RL20 - running bit stays one from start to completion or abort
module sas_top
	import sas_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic [31:0]      o_hrdata,
	output logic             o_hresp,
	input  wire logic        i_cmp,
	input  wire logic        i_rc_tick,
	input  wire logic        i_trig_compare,
	input  wire logic        i_trig_charge,
	input  wire logic [11:0] i_pin_level,
	output logic             o_sample,
	output logic             o_cal_mode,
	output logic [3:0]       o_channel,
	output logic [11:0]      o_dac_code,
	output logic             o_conv_done_flag
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_rst);

	sas_state_type state_r;
	sas_state_type state_nxt;
	logic [4:0]  cnt_r;
	logic [4:0]  cnt_nxt;
	logic        converter_on_r;
	logic        go_r;
	logic        offset_cal_req_r;
	logic [3:0]  channel_sel_r;
	logic        trigger_src_sel_r;
	logic [3:0]  analog_cfg_r;
	logic        result_justify_r;
	logic [2:0]  acq_time_sel_r;
	logic [2:0]  conv_clk_sel_r;
	logic [7:0]  result_high_r;
	logic [7:0]  result_low_r;
	logic        conv_done_flag_r;
	logic [3:0]  compare_mode_sel_r;
	logic [11:0] offset_r;
	logic        sample_r;
	logic        cal_mode_r;
	logic [11:0] dac_code;
	logic [11:0] sar_final;
	logic        tad_tick;
	logic        wr_pend_r;
	logic        rd_pend_r;
	logic [7:0]  dp_addr_r;
	logic        hreadyout_r;
	logic [31:0] hrdata_r;

	// analog pin mask from the port configuration field
	function automatic logic [11:0] analog_mask(input logic [3:0] cfg);
		if (cfg <= `SAS_CFG_ALL_AN)
			analog_mask = `SAS_AN_ALL;
		else
			analog_mask = `SAS_AN_ALL >> (cfg - `SAS_CFG_ALL_AN);
	endfunction

	// acquisition periods selected by the acquisition field
	function automatic logic [4:0] acq_len(input logic [2:0] sel);
		case (sel)
		3'h1: acq_len = `SAS_ACQ_LEN1; // RL3
		3'h2: acq_len = `SAS_ACQ_LEN2;
		3'h3: acq_len = `SAS_ACQ_LEN3;
		3'h4: acq_len = `SAS_ACQ_LEN4;
		3'h5: acq_len = `SAS_ACQ_LEN5;
		3'h6: acq_len = `SAS_ACQ_LEN6;
		3'h7: acq_len = `SAS_ACQ_LEN7;
		default: acq_len = 5'h00;
		endcase
	endfunction

	// bus address phase and data phase decode
	logic ap_take;
	logic ap_wr;
	logic ap_rd;
	logic wr_c0;
	logic wr_c1;
	logic wr_c2;
	logic wr_resh;
	logic wr_resl;
	logic wr_stat;
	logic wr_cmp;
	assign ap_take = i_hsel && i_htrans[1] && i_hready;
	assign ap_wr   = ap_take && i_hwrite && (i_hsize == `SAS_HSIZE_WORD);
	assign ap_rd   = ap_take && !i_hwrite;
	assign wr_c0   = wr_pend_r && (dp_addr_r == `SAS_OFS_CTRL0);
	assign wr_c1   = wr_pend_r && (dp_addr_r == `SAS_OFS_CTRL1);
	assign wr_c2   = wr_pend_r && (dp_addr_r == `SAS_OFS_CTRL2);
	assign wr_resh = wr_pend_r && (dp_addr_r == `SAS_OFS_RESH);
	assign wr_resl = wr_pend_r && (dp_addr_r == `SAS_OFS_RESL);
	assign wr_stat = wr_pend_r && (dp_addr_r == `SAS_OFS_STAT);
	assign wr_cmp  = wr_pend_r && (dp_addr_r == `SAS_OFS_CMP);

	// state decode
	logic st_idle;
	logic st_acq;
	logic st_conv;
	logic st_load;
	logic st_wait;
	logic busy;
	assign st_idle = (state_r == SAS_IDLE);
	assign st_acq  = (state_r == SAS_ACQ);
	assign st_conv = (state_r == SAS_CONV);
	assign st_load = (state_r == SAS_LOAD);
	assign st_wait = (state_r == SAS_WAIT);
	assign busy    = (state_r == SAS_DELAY) || st_acq || st_conv;

	// running bit: set by software or trigger, set wins over clears but not over converter off
	logic on_nxt;
	logic sw_go_set;
	logic sw_go_clr;
	logic trig_pulse;
	logic trig_hit;
	logic go_nxt;
	logic abort_now;
	assign on_nxt     = wr_c0 ? i_hwdata[`SAS_C0_ON] : converter_on_r;
	assign sw_go_set  = wr_c0 && i_hwdata[`SAS_C0_GO] && converter_on_r; // RL13
	assign sw_go_clr  = wr_c0 && !i_hwdata[`SAS_C0_GO];
	assign trig_pulse = trigger_src_sel_r ? i_trig_charge // RL16
		: (i_trig_compare && (compare_mode_sel_r == `SAS_CMP_SPECIAL));
	assign trig_hit   = converter_on_r && trig_pulse; // RL14 RL15
	assign go_nxt     = on_nxt && (sw_go_set || trig_hit // RL20
		|| (go_r && !sw_go_clr && !st_load)); // RL4
	assign abort_now  = busy && !go_r; // RL10

	// sequencing: delay or acquisition, conversion, load, wait
	logic tick_last;
	logic conv_begin;
	assign tick_last  = tad_tick && (cnt_nxt == 5'h00);
	assign conv_begin = (state_nxt == SAS_CONV) && !st_conv;
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		case (state_r)
		SAS_IDLE: begin
			cnt_nxt = 5'h00;
			if (go_r && acq_time_sel_r == 3'h0)
				state_nxt = SAS_DELAY; // RL1 RL12
			else if (go_r)
				state_nxt = SAS_ACQ; // RL2
		end
		SAS_DELAY: begin
			cnt_nxt = 5'(cnt_r + 5'h01);
			if (abort_now) begin
				state_nxt = SAS_WAIT;
				cnt_nxt   = 5'h00;
			end else if (cnt_nxt == `SAS_INSTR_CLKS) begin
				state_nxt = SAS_CONV; // RL12
				cnt_nxt   = 5'h00;
			end
		end
		SAS_ACQ: begin
			if (tad_tick)
				cnt_nxt = 5'(cnt_r + 5'h01);
			if (abort_now) begin
				state_nxt = SAS_WAIT;
				cnt_nxt   = 5'h00;
			end else if (cnt_nxt == acq_len(acq_time_sel_r)) begin
				state_nxt = SAS_CONV; // RL2 RL3
				cnt_nxt   = 5'h00;
			end
		end
		SAS_CONV: begin
			if (tad_tick)
				cnt_nxt = 5'(cnt_r + 5'h01);
			if (abort_now) begin
				state_nxt = SAS_WAIT; // RL10
				cnt_nxt   = 5'h00;
			end else if (cnt_nxt == `SAS_CONV_TADS) begin
				state_nxt = SAS_LOAD; // RL6
				cnt_nxt   = 5'h00;
			end
		end
		SAS_LOAD: begin
			state_nxt = SAS_WAIT;
			cnt_nxt   = 5'h00;
		end
		SAS_WAIT: begin
			if (tad_tick)
				cnt_nxt = 5'(cnt_r + 5'h01);
			if (cnt_nxt == `SAS_WAIT_TADS) begin
				state_nxt = SAS_IDLE; // RL11
				cnt_nxt   = 5'h00;
			end
		end
		default: begin
			state_nxt = SAS_IDLE;
			cnt_nxt   = 5'h00;
		end
		endcase
	end

	// state and counter registers
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			state_r <= SAS_IDLE;
			cnt_r   <= 5'h00;
		end else begin
			state_r <= state_nxt;
			cnt_r   <= cnt_nxt;
		end
	end

	// offset-corrected and justified result
	logic [11:0] corrected;
	logic [7:0]  res_high;
	logic [7:0]  res_low;
	assign corrected = (sar_final > offset_r) ? 12'(sar_final - offset_r)
		: `SAS_RST_RES; // RL17
	assign res_high  = result_justify_r ? {4'h0, corrected[11:8]} // RL19
		: corrected[11:4];
	assign res_low   = result_justify_r ? corrected[7:0]
		: {corrected[3:0], 4'h0};

	// control registers written by software
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			converter_on_r     <= 1'b0;
			go_r               <= 1'b0;
			channel_sel_r      <= 4'h0;
			trigger_src_sel_r  <= 1'b0;
			analog_cfg_r       <= 4'h0;
			result_justify_r   <= 1'b0;
			acq_time_sel_r     <= 3'h0;
			conv_clk_sel_r     <= 3'h0;
			compare_mode_sel_r <= 4'h0;
		end else begin
			converter_on_r <= on_nxt;
			go_r           <= go_nxt;
			if (wr_c0)
				channel_sel_r <= i_hwdata[`SAS_C0_CH_HI:`SAS_C0_CH_LO];
			if (wr_c1) begin
				trigger_src_sel_r <= i_hwdata[`SAS_C1_TRIG];
				analog_cfg_r      <= i_hwdata[`SAS_C1_CFG_HI:0];
			end
			if (wr_c2) begin
				result_justify_r <= i_hwdata[`SAS_C2_JUST];
				acq_time_sel_r   <= i_hwdata[`SAS_C2_ACQ_HI:`SAS_C2_ACQ_LO];
				conv_clk_sel_r   <= i_hwdata[`SAS_C2_CLK_HI:0];
			end
			if (wr_cmp)
				compare_mode_sel_r <= i_hwdata[`SAS_CMP_HI:0];
		end
	end

	// results, offset, calibration request and done flag
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			result_high_r    <= `SAS_RST_BYTE;
			result_low_r     <= `SAS_RST_BYTE;
			offset_r         <= `SAS_RST_RES;
			offset_cal_req_r <= 1'b0;
			conv_done_flag_r <= 1'b0;
		end else begin
			if (st_load && offset_cal_req_r)
				offset_r <= sar_final; // RL17
			if (st_load && !offset_cal_req_r) begin
				result_high_r <= res_high; // RL19
				result_low_r  <= res_low;
			end else begin
				if (wr_resh)
					result_high_r <= i_hwdata[7:0]; // RL10
				if (wr_resl)
					result_low_r <= i_hwdata[7:0];
			end
			if (wr_c0)
				offset_cal_req_r <= i_hwdata[`SAS_C0_CAL];
			else if (st_load)
				offset_cal_req_r <= 1'b0;
			if (st_load)
				conv_done_flag_r <= 1'b1; // RL4
			else if (wr_stat && !i_hwdata[`SAS_ST_FLAG])
				conv_done_flag_r <= 1'b0;
		end
	end

	// analog side controls: sample switch and dummy channel
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			sample_r   <= 1'b1;
			cal_mode_r <= 1'b0;
		end else begin
			sample_r   <= (state_nxt == SAS_IDLE) // RL4 RL11
				|| (state_nxt == SAS_ACQ); // RL2
			cal_mode_r <= offset_cal_req_r && (state_nxt != SAS_IDLE)
				&& (state_nxt != SAS_WAIT); // RL17
		end
	end

	// read data mux; port pins set analog read as zero
	logic [11:0] port_val;
	logic [7:0]  ctrl0_val;
	logic [31:0] rdata;
	assign port_val  = i_pin_level & ~analog_mask(analog_cfg_r); // RL9
	assign ctrl0_val = {offset_cal_req_r, 1'b0, channel_sel_r, go_r, // RL5
		converter_on_r};
	assign rdata =
		(dp_addr_r == `SAS_OFS_CTRL0) ? {24'h0, ctrl0_val} :
		(dp_addr_r == `SAS_OFS_CTRL1) ? {24'h0, trigger_src_sel_r,
			3'h0, analog_cfg_r} :
		(dp_addr_r == `SAS_OFS_CTRL2) ? {24'h0, result_justify_r, 1'b0,
			acq_time_sel_r, conv_clk_sel_r} :
		(dp_addr_r == `SAS_OFS_RESH)  ? {24'h0, result_high_r} :
		(dp_addr_r == `SAS_OFS_RESL)  ? {24'h0, result_low_r} :
		(dp_addr_r == `SAS_OFS_STAT)  ? {31'h0, conv_done_flag_r} :
		(dp_addr_r == `SAS_OFS_CMP)   ? {28'h0, compare_mode_sel_r} :
		(dp_addr_r == `SAS_OFS_PORT)  ? {20'h0, port_val} : 32'h0;

	// ahb-lite slave: writes zero wait, reads one wait state
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			wr_pend_r   <= 1'b0;
			rd_pend_r   <= 1'b0;
			dp_addr_r   <= 8'h00;
			hreadyout_r <= 1'b1;
			hrdata_r    <= 32'h0;
		end else begin
			wr_pend_r   <= ap_wr;
			rd_pend_r   <= ap_rd;
			hreadyout_r <= !ap_rd;
			if (ap_take)
				dp_addr_r <= i_haddr[7:0];
			if (rd_pend_r)
				hrdata_r <= rdata;
		end
	end

	// conversion clock and approximation register
	sas_tad_gen u_tad (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_run     (!st_idle),
		.i_sel     (conv_clk_sel_r),
		.i_rc_tick (i_rc_tick),
		.o_tick    (tad_tick)
	);
	sas_sar_core u_sar (
		.i_clk_sys (i_clk_sys),
		.i_rst     (i_rst),
		.i_start   (conv_begin),
		.i_step    (st_conv && tad_tick),
		.i_cmp     (i_cmp),
		.o_code    (dac_code),
		.o_final   (sar_final)
	);

	// outputs
	assign o_hreadyout      = hreadyout_r;
	assign o_hrdata         = hrdata_r;
	assign o_hresp          = 1'b0;
	assign o_sample         = sample_r;
	assign o_cal_mode       = cal_mode_r;
	assign o_channel        = channel_sel_r; // RL8
	assign o_dac_code       = dac_code;
	assign o_conv_done_flag = conv_done_flag_r;

	// checks
	a_load_sets_flag: assert property (st_load |=> // RL4
		conv_done_flag_r && !go_r || go_r && conv_done_flag_r)
		else $error("done flag not set after load");
	a_conv_length: assert property (st_conv && tad_tick && // RL6
		cnt_r == 5'(`SAS_CONV_TADS - 5'h01) && go_r |=> st_load)
		else $error("conversion not eleven periods");
	a_acq_exit: assert property (st_acq && tad_tick && go_r && // RL2
		cnt_r == 5'(acq_len(acq_time_sel_r) - 5'h01) |=> st_conv)
		else $error("acquisition length wrong");
	a_zero_acq: assert property (st_idle && go_r && // RL1
		acq_time_sel_r == 3'h0 |=> !sample_r ##3 !st_conv ##1 st_conv)
		else $error("zero acquisition start wrong");
	a_wait_end: assert property (st_wait && tad_tick && // RL11
		cnt_r == 5'h01 |=> st_idle ##1 sample_r)
		else $error("wait not two periods");
	a_abort_hold: assert property (st_conv && !go_r |=> // RL10
		st_wait && $stable(result_high_r) && $stable(result_low_r))
		else $error("abort changed result");
	a_trig_off: assert property (!converter_on_r |=> !go_r) // RL15
		else $error("running while converter off");
	a_go_held: assert property (busy && go_r && !sw_go_clr && // RL20
		!wr_c0 |=> go_r)
		else $error("running bit dropped early");
	a_port_zero: assert property (rd_pend_r && // RL9
		dp_addr_r == `SAS_OFS_PORT |=>
		(hrdata_r[11:0] & analog_mask(analog_cfg_r)) == 12'h000)
		else $error("analog pin read nonzero");
	a_cal_keep: assert property (st_load && offset_cal_req_r |=> // RL17
		$stable(result_low_r) && offset_r == $past(sar_final))
		else $error("calibration touched result");
	c_full_conv: cover property (st_conv ##[1:1000] st_load);
	c_abort: cover property (st_conv && !go_r);
	c_trigger: cover property (trig_hit && st_idle);
	c_calibrate: cover property (st_load && offset_cal_req_r);
endmodule

//--- hdl/sas_defines.svh
// register map, field positions and timing counts of the sequencer
`ifndef SAS_DEFINES_SVH
`define SAS_DEFINES_SVH
`define SAS_OFS_CTRL0    8'h00
`define SAS_OFS_CTRL1    8'h04
`define SAS_OFS_CTRL2    8'h08
`define SAS_OFS_RESH     8'h0C
`define SAS_OFS_RESL     8'h10
`define SAS_OFS_STAT     8'h14
`define SAS_OFS_CMP      8'h18
`define SAS_OFS_PORT     8'h1C
`define SAS_C0_ON        0
`define SAS_C0_GO        1
`define SAS_C0_CH_LO     2
`define SAS_C0_CH_HI     5
`define SAS_C0_CAL       7
`define SAS_C1_CFG_HI    3
`define SAS_C1_TRIG      7
`define SAS_C2_CLK_HI    2
`define SAS_C2_ACQ_LO    3
`define SAS_C2_ACQ_HI    5
`define SAS_C2_JUST      7
`define SAS_ST_FLAG      0
`define SAS_CMP_HI       3
`define SAS_CMP_SPECIAL  4'hB
`define SAS_CFG_ALL_AN   4'h3
`define SAS_AN_ALL       12'hFFF
`define SAS_HSIZE_WORD   3'h2
`define SAS_RST_BYTE     8'h00
`define SAS_RST_RES      12'h000
`define SAS_CONV_TADS    5'h0B
`define SAS_WAIT_TADS    5'h02
`define SAS_INSTR_CLKS   5'h04
`define SAS_ACQ_LEN1     5'h02
`define SAS_ACQ_LEN2     5'h04
`define SAS_ACQ_LEN3     5'h06
`define SAS_ACQ_LEN4     5'h08
`define SAS_ACQ_LEN5     5'h0C
`define SAS_ACQ_LEN6     5'h10
`define SAS_ACQ_LEN7     5'h14
`define SAS_DIV2         7'h02
`define SAS_DIV4         7'h04
`define SAS_DIV8         7'h08
`define SAS_DIV16        7'h10
`define SAS_DIV32        7'h20
`define SAS_DIV64        7'h40
`define SAS_RC_SEL       2'h3
`define SAS_SAR_MSB      12'h800
`endif

//--- hdl/sas_pkg.sv
// types shared by the converter sequencer modules
package sas_pkg;
	typedef enum logic [5:0] {
		SAS_IDLE  = 6'h01,
		SAS_DELAY = 6'h02,
		SAS_ACQ   = 6'h04,
		SAS_CONV  = 6'h08,
		SAS_LOAD  = 6'h10,
		SAS_WAIT  = 6'h20
	} sas_state_type;
endpackage

//--- hdl/sas_tad_gen.sv
// conversion clock tick generator from oscillator or rc ticks
`timescale 1ns/1ps
`include "sas_defines.svh"
module sas_tad_gen
	import sas_pkg::*;
(
	input  wire logic       i_clk_sys,
	input  wire logic       i_rst,
	input  wire logic       i_run,
	input  wire logic [2:0] i_sel,
	input  wire logic       i_rc_tick,
	output logic            o_tick
);
	logic [6:0] cnt_r;
	logic       tick_r;
	logic       use_rc;
	logic [6:0] last_cnt;

	// oscillator periods per conversion clock period
	function automatic logic [6:0] div_len(input logic [2:0] sel);
		case (sel)
		3'h0: div_len = `SAS_DIV2;
		3'h4: div_len = `SAS_DIV4;
		3'h1: div_len = `SAS_DIV8;
		3'h5: div_len = `SAS_DIV16;
		3'h2: div_len = `SAS_DIV32;
		3'h6: div_len = `SAS_DIV64;
		default: div_len = `SAS_DIV2;
		endcase
	endfunction

	// either pattern ending in 11 takes the rc oscillator
	assign use_rc   = (i_sel[1:0] == `SAS_RC_SEL); // RL7
	assign last_cnt = 7'(div_len(i_sel) - 7'h01); // RL7
	assign o_tick   = tick_r;

	// divider restarts its phase whenever the sequencer goes idle
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || !i_run) begin
			cnt_r  <= 7'h00;
			tick_r <= 1'b0;
		end else if (use_rc) begin
			cnt_r  <= 7'h00;
			tick_r <= i_rc_tick;
		end else if (cnt_r == last_cnt) begin
			cnt_r  <= 7'h00;
			tick_r <= 1'b1;
		end else begin
			cnt_r  <= 7'(cnt_r + 7'h01);
			tick_r <= 1'b0;
		end
	end
endmodule

//--- hdl/sas_sar_core.sv
// successive approximation register: one trial bit per step
`timescale 1ns/1ps
`include "sas_defines.svh"
module sas_sar_core
	import sas_pkg::*;
(
	input  wire logic        i_clk_sys,
	input  wire logic        i_rst,
	input  wire logic        i_start,
	input  wire logic        i_step,
	input  wire logic        i_cmp,
	output logic [11:0]      o_code,
	output logic [11:0]      o_final
);
	logic [11:0] trial_r;
	logic [11:0] ptr_r;
	logic [11:0] keep;

	// comparator high keeps the trial bit, low drops it
	assign keep    = i_cmp ? trial_r : (trial_r & ~ptr_r);
	assign o_final = keep;
	assign o_code  = trial_r;

	// msb first; the last bit is resolved combinationally at load
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			trial_r <= `SAS_RST_RES;
			ptr_r   <= `SAS_RST_RES;
		end else if (i_start) begin
			trial_r <= `SAS_SAR_MSB;
			ptr_r   <= `SAS_SAR_MSB;
		end else if (i_step) begin
			trial_r <= keep | (ptr_r >> 1);
			ptr_r   <= ptr_r >> 1;
		end
	end
endmodule

//--- tb/sas_top_bench.sv
// self-checking bench for the converter sequencer top
`timescale 1ns/1ps
`include "sas_defines.svh"
module sas_top_bench;
	import sas_pkg::*;
	logic        clk_sys, rst, hsel, hwrite, cmp, rc_tick;
	logic        trig_cmp, trig_chg, hreadyout, hresp, sample;
	logic        cal_mode, done_flag;
	logic [1:0]  htrans;
	logic [2:0]  hsize, rc_cnt;
	logic [3:0]  channel;
	logic [11:0] pin_level, dac_code, vin, off_v;
	logic [31:0] haddr, hwdata, hrdata, rd;
	int          error_cnt, checks_done, cycles, t, t2, tb;
	int          acq_len [7] = '{2, 4, 6, 8, 12, 16, 20};
	int          div_v [6] = '{2, 4, 8, 16, 32, 64};
	logic [2:0]  clk_code [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};

	// comparator model: dummy input level while calibrating
	assign cmp = ((cal_mode ? off_v : vin) >= dac_code);

	sas_top u_sas_top (
		.i_clk_sys(clk_sys), .i_rst(rst), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hreadyout),
		.o_hreadyout(hreadyout), .o_hrdata(hrdata), .o_hresp(hresp),
		.i_cmp(cmp), .i_rc_tick(rc_tick), .i_trig_compare(trig_cmp),
		.i_trig_charge(trig_chg), .i_pin_level(pin_level),
		.o_sample(sample), .o_cal_mode(cal_mode), .o_channel(channel),
		.o_dac_code(dac_code), .o_conv_done_flag(done_flag)
	);

	// system clock, 10 ns period
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// rc oscillator tick every seven system clocks
	always @(posedge clk_sys) begin
		rc_cnt <= (rc_cnt == 3'h6) ? 3'h0 : rc_cnt + 3'h1;
		rc_tick <= (rc_cnt == 3'h6);
	end

	// hang guard
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			error_cnt++;
			$display("CHECK FAILED run length expected done seen timeout");
			report_and_stop;
		end
	end

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	task automatic chk_reg(input string nm, input logic [31:0] exp,
		input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_pin(input string nm, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %b seen %b", nm, exp, got);
		end
	endtask

	// address phase, held until hready is sampled high
	task automatic bus_req(input logic [7:0] a, input logic wr);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		hsize <= `SAS_HSIZE_WORD;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		htrans <= 2'h0;
	endtask

	task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
		bus_req(a, 1'b1);
		hwdata <= d;
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		#1; // let the written register settle before callers look
	endtask

	task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
		bus_req(a, 1'b0);
		@(posedge clk_sys);
		while (hreadyout !== 1'b1) @(posedge clk_sys);
		d = hrdata;
	endtask

	// poll the running bit until it drops
	task automatic wait_idle;
		int n = 0;
		rd = 32'h2;
		while (rd[1] !== 1'b0 && n < 400) begin
			bus_read(`SAS_OFS_CTRL0, rd);
			n++;
		end
		chk_pin("running bit", 1'b0, rd[1]);
	endtask

	// enable first, then start; count sampling cycles after the start
	task automatic conv(input logic [2:0] acq, input logic [2:0] ck,
		input logic just, input logic cal);
		while (sample !== 1'b1) @(posedge clk_sys);
		bus_write(`SAS_OFS_STAT, 32'h0);
		bus_write(`SAS_OFS_CTRL2, {24'h0, just, 1'b0, acq, ck});
		bus_write(`SAS_OFS_CTRL0, {24'h0, cal, 1'b0, 4'h3, 2'h1});
		bus_write(`SAS_OFS_CTRL0, {24'h0, cal, 1'b0, 4'h3, 2'h3});
		t = 0;
		while (sample === 1'b1 && t < 2000) begin
			@(posedge clk_sys);
			t++;
		end
		// clocks from sampling end to the first trial word
		t2 = 0;
		while (acq == 3'h0 && dac_code !== `SAS_SAR_MSB && t2 < 2000) begin
			@(posedge clk_sys);
			t2++;
		end
		bus_read(`SAS_OFS_CTRL0, rd);
		chk_pin("running in progress", 1'b1, rd[1]);
		bus_read(`SAS_OFS_STAT, rd);
		chk_reg("status in progress", 32'h0, rd);
		wait_idle;
	endtask

	task automatic port_chk(input logic [3:0] cfg, input logic [11:0] exp);
		bus_write(`SAS_OFS_CTRL1, {28'h0, cfg});
		bus_read(`SAS_OFS_PORT, rd);
		chk_reg("port read", {20'h0, exp}, rd);
	endtask

	task automatic res_chk(input logic [7:0] hi, input logic [7:0] lo);
		bus_read(`SAS_OFS_RESH, rd);
		chk_reg("result high", {24'h0, hi}, rd);
		bus_read(`SAS_OFS_RESL, rd);
		chk_reg("result low", {24'h0, lo}, rd);
		bus_write(`SAS_OFS_STAT, 32'h0);
	endtask

	task automatic trig_try(input logic chg, input logic exp_go);
		@(posedge clk_sys);
		if (chg) trig_chg <= 1'b1;
		else trig_cmp <= 1'b1;
		@(posedge clk_sys);
		trig_chg <= 1'b0;
		trig_cmp <= 1'b0;
		repeat (12) @(posedge clk_sys);
		chk_pin("trigger start", exp_go, ~sample);
		wait_idle;
	endtask

	initial begin
		{hsel, hwrite, trig_cmp, trig_chg, rc_tick} = 5'h00;
		{haddr, hwdata} = 64'h0;
		htrans = 2'h0;
		hsize = `SAS_HSIZE_WORD;
		rc_cnt = 3'h0;
		pin_level = 12'hFFF;
		vin = 12'h5A3;
		off_v = 12'h000;
		{error_cnt, checks_done, cycles} = 96'h0;
		rst = 1'b1;
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		for (int a = 0; a < 9; a++) begin
			bus_read((a == 8) ? 8'h40 : 8'(a * 4), rd);
			chk_reg("reset value", 32'h0, rd);
		end
		chk_pin("okay response", 1'b0, hresp);
		chk_pin("sampling at rest", 1'b1, sample);
		$display("test reset done");
		port_chk(4'h4, 12'h800);
		port_chk(4'hC, 12'hFF8);
		port_chk(4'hF, 12'hFFF);
		bus_write(`SAS_OFS_CTRL0, 32'h29);
		chk_reg("channel", 32'hA, {28'h0, channel});
		$display("test port done");
		conv(3'h0, 3'h0, 1'b1, 1'b0);
		chk_reg("start delay", 32'(`SAS_INSTR_CLKS), 32'(t2));
		bus_read(`SAS_OFS_STAT, rd);
		chk_reg("done flag", 32'h1, rd);
		bus_write(`SAS_OFS_STAT, 32'h1);
		chk_pin("flag kept", 1'b1, done_flag);
		res_chk(8'h05, 8'hA3);
		chk_pin("flag cleared", 1'b0, done_flag);
		conv(3'h0, 3'h0, 1'b0, 1'b0);
		res_chk(8'h5A, 8'h30);
		$display("test direct conversion done");
		for (int c = 1; c < 8; c++) begin
			conv(3'(c), 3'h0, 1'b1, 1'b0);
			if (c == 1) tb = t;
			chk_reg("acq length", 32'((acq_len[c-1] - 2) * 2), 32'(t - tb));
		end
		$display("test acquisition sweep done");
		for (int c = 0; c < 6; c++) begin
			conv(3'h1, clk_code[c], 1'b1, 1'b0);
			if (c == 0) tb = t;
			chk_reg("tad length", 32'(2 * (div_v[c] - 2)), 32'(t - tb));
			res_chk(8'h05, 8'hA3);
		end
		conv(3'h1, 3'h3, 1'b1, 1'b0);
		res_chk(8'h05, 8'hA3);
		conv(3'h2, 3'h7, 1'b1, 1'b0);
		res_chk(8'h05, 8'hA3);
		$display("test clock sweep done");
		off_v = 12'h004;
		conv(3'h0, 3'h0, 1'b1, 1'b1);
		bus_read(`SAS_OFS_CTRL0, rd);
		chk_pin("cal bit clears", 1'b0, rd[7]);
		res_chk(8'h05, 8'hA3);
		conv(3'h0, 3'h0, 1'b1, 1'b0);
		res_chk(8'h05, 8'h9F);
		$display("test calibration done");
		bus_write(`SAS_OFS_RESH, 32'h12);
		bus_write(`SAS_OFS_RESL, 32'h34);
		bus_write(`SAS_OFS_CTRL2, 32'h86);
		bus_write(`SAS_OFS_CTRL0, 32'h0D);
		bus_write(`SAS_OFS_CTRL0, 32'h0F);
		repeat (100) @(posedge clk_sys);
		chk_pin("converting", 1'b0, sample);
		bus_write(`SAS_OFS_CTRL0, 32'h0D);
		t = 0;
		while (sample === 1'b0 && t < 400) begin
			@(posedge clk_sys);
			t++;
		end
		chk_pin("wait after abort", 1'b1, t >= 60 && t <= 140);
		chk_pin("no flag on abort", 1'b0, done_flag);
		res_chk(8'h12, 8'h34);
		$display("test abort done");
		bus_write(`SAS_OFS_CTRL2, 32'h80);
		bus_write(`SAS_OFS_CMP, {28'h0, `SAS_CMP_SPECIAL});
		bus_write(`SAS_OFS_CTRL0, 32'h0);
		trig_try(1'b0, 1'b0);
		bus_write(`SAS_OFS_CTRL0, 32'h01);
		bus_write(`SAS_OFS_CMP, 32'h0);
		trig_try(1'b0, 1'b0);
		bus_write(`SAS_OFS_CMP, {28'h0, `SAS_CMP_SPECIAL});
		trig_try(1'b0, 1'b1);
		chk_pin("trigger flag", 1'b1, done_flag);
		bus_write(`SAS_OFS_CTRL1, 32'h80);
		trig_try(1'b0, 1'b0);
		trig_try(1'b1, 1'b1);
		$display("test triggers done");
		report_and_stop;
	end
endmodule
